// >>> bench/line_cycle_energy_accumulator_tb.sv
// Purpose: self-checking bench for the line-cycle energy accumulator
// Assumes: RESULT_SHIFT 0 so sums show in the low result bits
// Notes:   reactive checks look at sign and non-zero only; filter gain not modelled
`timescale 1ns/1ps
`default_nettype none
`include "lce_defines.svh"

module line_cycle_energy_accumulator_tb;
  logic                      mclk = 1'b0;
  logic                      rst = 1'b1;
  logic                      volt_zx = 1'b0;
  logic signed [23:0]        active_power = 24'h000000;
  logic                      sample_valid = 1'b0;
  logic signed [15:0]        volt_sample = 16'h0000;
  logic signed [15:0]        curr_sample = 16'h0000;
  wire logic [5:0]           reg_addr;
  wire logic                 reg_wr;
  wire logic [15:0]          reg_wdata;
  wire logic [15:0]          mode_word;
  wire logic [4:0]           irq_enable;
  wire logic [4:0]           status_clr;
  wire logic [23:0]          reg_rdata;
  wire logic signed [23:0]   react;
  wire logic [4:0]           status;
  wire logic                 irq_n_out;
  wire logic                 irq_n_oe_n;
  wire logic                 irq_line;
  int                        failures = 0;
  int                        n_compared = 0;
  int                        cycles = 0;

  // pull-up on the open-drain request line
  assign irq_line = irq_n_oe_n ? 1'b1 : irq_n_out;

  always #4 mclk = ~mclk;

  line_cycle_energy_accumulator #(.RESULT_SHIFT(0)) DUT
  (
    .MCLK(mclk), .RST(rst), .VOLT_ZX(volt_zx),
    .ACTIVE_POWER(active_power), .SAMPLE_VALID(sample_valid),
    .VOLT_SAMPLE(volt_sample), .CURR_SAMPLE(curr_sample),
    .MODE_WORD(mode_word), .IRQ_ENABLE(irq_enable),
    .STATUS_CLR(status_clr), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .LINE_REACTIVE_ENERGY(react), .STATUS(status),
    .IRQ_N_OUT(irq_n_out), .IRQ_N_OE_N(irq_n_oe_n)
  );

  meter_host host
  (
    .rdata(reg_rdata), .status(status), .mclk(mclk), .addr(reg_addr),
    .wr(reg_wr), .wdata(reg_wdata), .mode(mode_word),
    .ien(irq_enable), .clr(status_clr)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // samples sit well clear of the crossing so no period edge drops one
  task automatic half(input logic signed [23:0] a, b, c);
    logic signed [23:0] s [3];
    s = '{a, b, c};
    volt_zx <= ~volt_zx;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 3; i++)
    begin
      active_power <= s[i];
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      @(posedge mclk);
    end
    repeat (6) @(posedge mclk);
  endtask : half

  task automatic run_period(input logic [15:0] m, input logic [4:0] e,
                            input logic signed [23:0] a, b, c,
                            input logic [23:0] exp);
    logic [23:0] d;
    host.set_ctl(16'h0000, e);
    host.clear_status(5'h1F);
    host.set_ctl(m, e);
    fork
      host.get_result(1'b1, d);
      repeat (5) half(a, b, c);
    join
    check(d, exp);
    host.read_reg(`LCE_ADDR_LINE_ACTIVE, d);
    check(d, exp);
  endtask : run_period

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_regs();
    logic [23:0] d;
    host.read_reg(`LCE_ADDR_HALF_CYCLES, d);
    check(d, 24'h000000);
    check({19'h0, status}, 24'h000000);
    check(react, 24'h000000);
    host.write_reg(`LCE_ADDR_HALF_CYCLES, 16'hFFFF);
    host.read_reg(`LCE_ADDR_HALF_CYCLES, d);
    check(d, 24'h00FFFF);
    host.write_reg(`LCE_ADDR_LINE_ACTIVE, 16'h1234);
    host.read_reg(`LCE_ADDR_LINE_ACTIVE, d);
    check(d, 24'h000000);
    host.read_reg(6'h3F, d);
    check(d, 24'h000000);
    host.write_reg(`LCE_ADDR_HALF_CYCLES, 16'h0002);
    $display("test registers done");
  endtask : test_regs

  task automatic test_line();
    run_period(16'h0080, 5'h04, 24'h000064, 24'h000054, 24'hFFFFAD,
               24'h000170);
    check({19'h0, status}, 24'h000004);
    check({23'h0, irq_line}, 24'h000000);
    host.clear_status(5'h04);
    check({23'h0, irq_line}, 24'h000001);
    $display("test line cycle done");
  endtask : test_line

  task automatic test_sign();
    run_period(16'h0080, 5'h18, 24'h000064, 24'hFFFED4, 24'h000064,
               24'hFFFF38);
    check({19'h0, status}, 24'h00001C);
    check({23'h0, irq_line}, 24'h000001);
    run_period(16'h8080, 5'h18, 24'h000064, 24'hFFFED4, 24'h000064,
               24'h000190);
    check({23'h0, irq_line}, 24'h000000);
    host.clear_status(5'h18);
    check({23'h0, irq_line}, 24'h000001);
    $display("test positive only done");
  endtask : test_sign

  // voltage leads current by th; crossings follow the voltage
  // small amplitude keeps eight half cycles inside the 24-bit result
  task automatic test_react(input real th, input logic neg);
    real ph;
    active_power <= 24'h000000;
    host.set_ctl(16'h0000, 5'h00);
    host.clear_status(5'h1F);
    host.write_reg(`LCE_ADDR_HALF_CYCLES, 16'h0008);
    host.set_ctl(16'h0080, 5'h00);
    for (int k = 0; k < 2560; k++)
    begin
      ph = 6.2831853 * k / 64.0;
      if (k % 32 == 0)
        volt_zx <= ~volt_zx;
      volt_sample <= 16'($rtoi(3000.0 * $sin(ph)));
      curr_sample <= 16'($rtoi(3000.0 * $sin(ph - th)));
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      @(posedge mclk);
    end
    check({23'h0, react[23]}, {23'h0, neg});
    check({23'h0, react == 24'h0}, 24'h000000);
    check({23'h0, status[2]}, 24'h000001);
    $display("test reactive done");
  endtask : test_react

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    test_regs();
    test_line();
    test_sign();
    test_react(1.5707963, 1'b0);
    test_react(-1.5707963, 1'b1);
    report_and_stop();
  end
endmodule : line_cycle_energy_accumulator_tb

`default_nettype wire

// >>> bench/meter_host.sv
// Purpose: host model, register access and result pickup
// Assumes: drives just after posedge mclk by non-blocking assignment
// Notes:   status clears are left to the caller except the skipped end
`timescale 1ns/1ps
`default_nettype none
`include "lce_defines.svh"

module meter_host
(
  input  wire logic [`LCE_RES_W-1:0]  rdata,
  input  wire logic [`LCE_ST_W-1:0]   status,
  input  wire logic                   mclk,
  output logic      [`LCE_ADDR_W-1:0] addr,
  output logic                        wr,
  output logic      [15:0]            wdata,
  output logic      [15:0]            mode,
  output logic      [`LCE_ST_W-1:0]   ien,
  output logic      [`LCE_ST_W-1:0]   clr
);
  initial
  begin
    {addr, wr, wdata, mode, ien, clr} = 49'h0;
  end

  // ------------------------------------------------------------------
  // register and control tasks
  // ------------------------------------------------------------------
  task automatic write_reg(input logic [`LCE_ADDR_W-1:0] a,
                           input logic [15:0]            d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : write_reg

  // the answer is registered, so it is taken two edges after the address
  task automatic read_reg(input  logic [`LCE_ADDR_W-1:0] a,
                          output logic [`LCE_RES_W-1:0]  d);
    @(posedge mclk);
    addr <= a;
    repeat (2) @(posedge mclk);
    d = rdata;
  endtask : read_reg

  task automatic set_ctl(input logic [15:0] m, input logic [4:0] e);
    @(posedge mclk);
    mode <= m;
    ien  <= e;
  endtask : set_ctl

  // the extra edge lets the cleared flags land before anyone looks
  task automatic clear_status(input logic [4:0] m);
    @(posedge mclk);
    clr <= m;
    @(posedge mclk);
    clr <= 5'h00;
    @(posedge mclk);
  endtask : clear_status

  task automatic wait_end();
    do
      @(posedge mclk);
    while (status[`LCE_ST_CYCLE_END] !== 1'b1);
  endtask : wait_end

  // the first period after entering the mode starts mid-state
  task automatic get_result(input  logic                 skip,
                            output logic [`LCE_RES_W-1:0] d);
    if (skip)
    begin
      wait_end();
      clear_status(5'h04);
    end
    wait_end();
    read_reg(`LCE_ADDR_LINE_ACTIVE, d);
  endtask : get_result
endmodule : meter_host

`default_nettype wire

// >>> hw/line_cycle_energy_accumulator.sv
// Purpose: line-cycle active and reactive energy accumulation
// Assumes: ACTIVE_POWER and samples come from logic on MCLK;
//          VOLT_ZX is a raw pin and is synchronised here
// Notes:   results refresh only at the end of each period
`timescale 1ns/1ps
`default_nettype none
`include "lce_defines.svh"

// Summary of operation
// R1 - mode bit 7 enters line-cycle mode
// R2 - periods start and end on voltage crossings
// R3 - active power summed into line active result
// R4 - period length from 16-bit half-cycle register
// R5 - period end sets cycle-end status bit 2
// R6 - enabled cycle-end flag pulls interrupt low
// R7 - new period starts right after each one
// R8 - host discards first result after entering mode
// R9 - mode bit 15 selects positive-only, off at reset
// R10 - positive-only mode drops every negative sample
// R11 - enabled sign changes pull interrupt low in positive-only mode
// R12 - sign changes set went-positive or went-negative
// R13 - samples below no-load threshold not accumulated
// R14 - reactive product uses +90 degree current
// R15 - reactive power is low-pass filtered product
// R16 - reactive period shares count and cycle end
// R17 - reactive power summed into signed result
// R18 - reactive result sign gives power direction
// R19 - every voltage crossing counts one half cycle
// R20 - results held while next period accumulates
module line_cycle_energy_accumulator
  import lce_pkg::*;
#(
  parameter int RESULT_SHIFT = 24
)
(
  input  wire logic                         MCLK,
  input  wire logic                         RST,
  input  wire logic                         VOLT_ZX,
  input  wire logic signed [`LCE_RES_W-1:0] ACTIVE_POWER,
  input  wire logic                         SAMPLE_VALID,
  input  wire logic signed [`LCE_SMP_W-1:0] VOLT_SAMPLE,
  input  wire logic signed [`LCE_SMP_W-1:0] CURR_SAMPLE,
  input  wire logic [15:0]                  MODE_WORD,
  input  wire logic [`LCE_ST_W-1:0]         IRQ_ENABLE,
  input  wire logic [`LCE_ST_W-1:0]         STATUS_CLR,
  input  wire logic [`LCE_ADDR_W-1:0]       REG_ADDR,
  input  wire logic                         REG_WR,
  input  wire logic [15:0]                  REG_WDATA,
  output logic [`LCE_RES_W-1:0]             REG_RDATA,
  output logic signed [`LCE_RES_W-1:0]      LINE_REACTIVE_ENERGY,
  output logic [`LCE_ST_W-1:0]              STATUS,
  output logic                              IRQ_N_OUT,
  output logic                              IRQ_N_OE_N
);

  if (RESULT_SHIFT < 0 || RESULT_SHIFT > `LCE_ACC_W - `LCE_RES_W)
  begin : g_bad_shift
    $error("line_cycle_energy_accumulator: bad RESULT_SHIFT");
  end

  // --------------------------------------------------------------------
  // reactive path
  // --------------------------------------------------------------------
  power_path_if pw ();

  assign pw.volt  = VOLT_SAMPLE;
  assign pw.curr  = CURR_SAMPLE;
  assign pw.valid = SAMPLE_VALID;

  reactive_power_path u_react
  (
    .MCLK (MCLK),
    .RST  (RST),
    .pw   (pw)
  );

  // --------------------------------------------------------------------
  // combinational decode
  // --------------------------------------------------------------------
  acc_state_t                   s;
  acc_state_t                   next_s;
  logic                         mode_on;
  logic                         pos_only;
  logic                         zx_edge;
  logic                         p_neg;
  logic                         p_big;
  logic                         q_big;
  logic                         active_ok;
  logic                         react_ok;
  logic                         period_done;
  logic [`LCE_RES_W-1:0]        p_mag;
  logic [`LCE_RES_W-1:0]        q_mag;
  logic signed [`LCE_ACC_W-1:0] p_ext;
  logic signed [`LCE_ACC_W-1:0] q_ext;

  assign mode_on  = MODE_WORD[`LCE_MODE_LINE_CYCLE];        // see R1
  assign pos_only = MODE_WORD[`LCE_MODE_POS_ONLY];          // see R9
  // both edges of the crossing pin count                  see R19
  assign zx_edge  = s.zx_sync ^ s.zx_prev;
  assign p_neg    = ACTIVE_POWER[`LCE_RES_W-1];
  assign p_mag    = p_neg ? -ACTIVE_POWER : ACTIVE_POWER;
  assign q_mag    = pw.react[`LCE_RES_W-1] ? -pw.react : pw.react;
  assign p_big    = p_mag >= `LCE_NOLOAD_THRESH;            // see R13
  assign q_big    = q_mag >= `LCE_NOLOAD_THRESH;            // see R13
  // negatives go regardless of the no-load level           see R10
  assign active_ok = SAMPLE_VALID && p_big && !(pos_only && p_neg);
  assign react_ok  = pw.react_valid && q_big;
  assign p_ext = {{(`LCE_ACC_W-`LCE_RES_W){ACTIVE_POWER[`LCE_RES_W-1]}},
                  ACTIVE_POWER};
  assign q_ext = {{(`LCE_ACC_W-`LCE_RES_W){pw.react[`LCE_RES_W-1]}},
                  pw.react};
  assign period_done = s.state == ST_ACCUM && mode_on && zx_edge &&
                       s.remain <= 16'h0001;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    next_s         = s;
    // only the second stage reads the first synchroniser flop
    next_s.zx_meta = VOLT_ZX;
    next_s.zx_sync = s.zx_meta;
    next_s.zx_prev = s.zx_sync;

    if (REG_WR && REG_ADDR == `LCE_ADDR_HALF_CYCLES)
      next_s.half_cycles = REG_WDATA;                       // see R4

    case (s.state)
      ST_IDLE:
      begin
        if (mode_on)
          next_s.state = ST_WAIT_ZX;                        // see R1
      end
      ST_WAIT_ZX:
      begin
        if (!mode_on)
          next_s.state = ST_IDLE;
        else if (zx_edge)
        begin
          // start aligned to a crossing                    see R2
          next_s.state  = ST_ACCUM;
          next_s.remain = s.half_cycles;
          next_s.acc_p  = `LCE_ACC_ZERO;
          next_s.acc_q  = `LCE_ACC_ZERO;
        end
      end
      ST_ACCUM:
      begin
        if (!mode_on)
          next_s.state = ST_IDLE;
        else if (period_done)
        begin
          // latch and restart at once; the sample on this edge
          // belongs to neither period, a one-sample trade-off
          next_s.res_p  = s.acc_p[RESULT_SHIFT +: `LCE_RES_W]; // see R3
          next_s.res_q  = s.acc_q[RESULT_SHIFT +: `LCE_RES_W]; // see R17
          next_s.acc_p  = `LCE_ACC_ZERO;                    // see R20
          next_s.acc_q  = `LCE_ACC_ZERO;
          next_s.remain = s.half_cycles;                    // see R7
        end
        else
        begin
          if (active_ok)
            next_s.acc_p = s.acc_p + p_ext;                 // see R3
          if (react_ok)
            next_s.acc_q = s.acc_q + q_ext;                 // see R16
          if (zx_edge)
            next_s.remain = s.remain - 16'h0001;            // see R19
        end
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase

    // status: a set in the clearing cycle wins
    next_s.cycle_end = (s.cycle_end & ~STATUS_CLR[`LCE_ST_CYCLE_END]) |
                       period_done;                         // see R5
    next_s.went_pos  = s.went_pos & ~STATUS_CLR[`LCE_ST_WENT_POS];
    next_s.went_neg  = s.went_neg & ~STATUS_CLR[`LCE_ST_WENT_NEG];
    if (SAMPLE_VALID && p_big)
    begin
      next_s.sign_known = 1'b1;
      next_s.last_pos   = !p_neg;
      if (s.sign_known && s.last_pos == p_neg)
      begin
        if (p_neg)
          next_s.went_neg = 1'b1;                           // see R12
        else
          next_s.went_pos = 1'b1;                           // see R12
      end
    end

    case (REG_ADDR)
      `LCE_ADDR_LINE_ACTIVE: next_s.rdata = s.res_p;
      `LCE_ADDR_HALF_CYCLES: next_s.rdata = {8'h00, s.half_cycles};
      default:               next_s.rdata = `LCE_RES_ZERO;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s             <= '0;
      s.state       <= ST_IDLE;
      s.half_cycles <= `LCE_HALF_CYCLES_RST;
    end
    else
      s <= next_s;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  logic irq_req;

  assign REG_RDATA            = s.rdata;
  assign LINE_REACTIVE_ENERGY = s.res_q;                    // see R18
  always_comb
  begin
    STATUS                    = '0;
    STATUS[`LCE_ST_CYCLE_END] = s.cycle_end;
    STATUS[`LCE_ST_WENT_POS]  = s.went_pos;
    STATUS[`LCE_ST_WENT_NEG]  = s.went_neg;
  end
  // direction flags only interrupt in positive-only mode
  assign irq_req =
    (s.cycle_end && IRQ_ENABLE[`LCE_ST_CYCLE_END]) ||       // see R6
    (pos_only && ((s.went_pos && IRQ_ENABLE[`LCE_ST_WENT_POS]) ||
                  (s.went_neg && IRQ_ENABLE[`LCE_ST_WENT_NEG]))); // see R11
  // open drain: the pin level is always low, only the enable moves
  assign IRQ_N_OUT  = 1'b0;
  assign IRQ_N_OE_N = !irq_req;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_mode_off_idles;
    !mode_on |=> s.state == ST_IDLE;
  endproperty
  a_mode_off_idles : assert property (p_mode_off_idles) // see R1
    else $error("state not idle with line-cycle mode off");

  property p_enter_accum;
    s.state == ST_WAIT_ZX && mode_on && zx_edge
      |=> s.state == ST_ACCUM && s.remain == $past(s.half_cycles);
  endproperty
  a_enter_accum : assert property (p_enter_accum) // see R2
    else $error("period did not start on a crossing");

  property p_flag_set;
    period_done |=> s.cycle_end && STATUS[`LCE_ST_CYCLE_END];
  endproperty
  a_flag_set : assert property (p_flag_set) // see R5
    else $error("cycle end flag not set at period end");

  property p_irq_low;
    s.cycle_end && IRQ_ENABLE[`LCE_ST_CYCLE_END] |-> !IRQ_N_OE_N;
  endproperty
  a_irq_low : assert property (p_irq_low) // see R6
    else $error("interrupt not driven for enabled cycle end");

  property p_restart;
    period_done |=> s.state == ST_ACCUM &&
                    s.remain == $past(s.half_cycles) &&
                    s.res_p == $past(s.acc_p[RESULT_SHIFT +: `LCE_RES_W]);
  endproperty
  a_restart : assert property (p_restart) // see R7
    else $error("period did not restart with a latched result");

  property p_result_held;
    !period_done |=> $stable(s.res_p) && $stable(s.res_q);
  endproperty
  a_result_held : assert property (p_result_held) // see R20
    else $error("result changed outside a period end");

  property p_drop_negative;
    s.state == ST_ACCUM && mode_on && !period_done && pos_only &&
    SAMPLE_VALID && p_neg |=> s.acc_p == $past(s.acc_p);
  endproperty
  a_drop_negative : assert property (p_drop_negative) // see R10
    else $error("negative sample accumulated in positive-only mode");

  property p_noload;
    s.state == ST_ACCUM && !period_done && !p_big
      |=> s.acc_p == $past(s.acc_p);
  endproperty
  a_noload : assert property (p_noload) // see R13
    else $error("sub-threshold sample accumulated");

  property p_went_pos;
    SAMPLE_VALID && p_big && !p_neg && s.sign_known && !s.last_pos
      |=> s.went_pos ##1
          (s.went_pos || $past(STATUS_CLR[`LCE_ST_WENT_POS]));
  endproperty
  a_went_pos : assert property (p_went_pos) // see R12
    else $error("went-positive flag not set on sign change");

  property p_went_neg;
    SAMPLE_VALID && p_big && p_neg && s.sign_known && s.last_pos
      |=> s.went_neg ##1
          (s.went_neg || $past(STATUS_CLR[`LCE_ST_WENT_NEG]));
  endproperty
  a_went_neg : assert property (p_went_neg) // see R12
    else $error("went-negative flag not set on sign change");

  property p_count_down;
    s.state == ST_ACCUM && mode_on && zx_edge && s.remain > 16'h0001
      |=> s.remain == $past(s.remain) - 16'h0001;
  endproperty
  a_count_down : assert property (p_count_down) // see R19
    else $error("half cycle counter did not step on a crossing");

  c_period_end : cover property (period_done ##1 s.cycle_end);
  c_went_pos   : cover property ($rose(s.went_pos));
  c_went_neg   : cover property ($rose(s.went_neg));
  c_irq        : cover property ($fell(IRQ_N_OE_N));

endmodule : line_cycle_energy_accumulator

`default_nettype wire

// >>> hw/reactive_power_path.sv
// Purpose: reactive power from voltage and a +90 degree current
// Assumes: samples arrive with pw.valid, one per sample period
// Notes:   the phase shift is a negated leaky integrator, so its
//          gain falls with frequency; calibration absorbs that
`timescale 1ns/1ps
`default_nettype none
`include "lce_defines.svh"

module reactive_power_path
  import lce_pkg::*;
#(
  parameter int INT_LEAK  = 8,
  parameter int INT_GAIN  = 6,
  parameter int LPF_SHIFT = 10
)
(
  input wire logic   MCLK,
  input wire logic   RST,
  power_path_if.path pw
);

  if (INT_LEAK < 1 || INT_LEAK > 30 || INT_GAIN < 0 || INT_GAIN > 30 ||
      LPF_SHIFT < 1 || LPF_SHIFT > 30)
  begin : g_bad_param
    $error("reactive_power_path: shift parameter out of range");
  end

  rp_state_t          s;
  rp_state_t          next_s;
  logic signed [31:0] curr_ext;
  logic signed [31:0] shifted_w;
  logic signed [15:0] shifted;
  logic signed [31:0] prod;

  always_comb
  begin
    next_s    = s;
    curr_ext  = {{16{pw.curr[15]}}, pw.curr};
    shifted_w = -(s.integ >>> INT_GAIN);
    shifted   = shifted_w[15:0];
    prod      = pw.volt * shifted;                         // see R14
    next_s.valid = 1'b0;
    if (pw.valid)
    begin
      next_s.integ = s.integ + curr_ext - (s.integ >>> INT_LEAK);
      // keeping only the dc term of v * i'                  see R15
      next_s.lpf   = s.lpf + ((prod - s.lpf) >>> LPF_SHIFT);
      next_s.react = s.lpf[31:8];
      next_s.valid = 1'b1;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      s <= '0;
    else
      s <= next_s;
  end

  assign pw.react       = s.react;
  assign pw.react_valid = s.valid;

  property p_react_follows;
    @(posedge MCLK) disable iff (RST)
    pw.valid |=> pw.react_valid && pw.react == $past(s.lpf[31:8]);
  endproperty
  a_react_follows : assert property (p_react_follows) // see R15
    else $error("reactive result not produced after a sample");

endmodule : reactive_power_path

`default_nettype wire

// >>> shared/lce_defines.svh
// Purpose: named constants of the line-cycle energy accumulator
// Assumes: included by bare name; definitions only
// Notes:   offsets are byte addresses on the register port
`ifndef LCE_DEFINES_SVH
`define LCE_DEFINES_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define LCE_ADDR_W            6
`define LCE_ADDR_LINE_ACTIVE  6'h04
`define LCE_ADDR_HALF_CYCLES  6'h1C
`define LCE_HALF_CYCLES_RST   16'h0000

// ----------------------------------------------------------------------
// mode word and status bits
// ----------------------------------------------------------------------
`define LCE_MODE_LINE_CYCLE   7
`define LCE_MODE_POS_ONLY     15
`define LCE_ST_CYCLE_END      2
`define LCE_ST_WENT_POS       3
`define LCE_ST_WENT_NEG       4
`define LCE_ST_W              5

// ----------------------------------------------------------------------
// data path
// ----------------------------------------------------------------------
`define LCE_ACC_W             48
`define LCE_RES_W             24
`define LCE_SMP_W             16
// 0.001 % of a 2^23 full scale multiplier output, rounded up
`define LCE_NOLOAD_THRESH     24'h000054
`define LCE_ACC_ZERO          48'h000000000000
`define LCE_RES_ZERO          24'h000000

`endif

// >>> shared/lce_pkg.sv
// Purpose: types shared by the accumulator and its reactive path
// Assumes: lce_defines.svh on the include path
// Notes:   one packed struct holds all state of each module
`default_nettype none
`include "lce_defines.svh"

package lce_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_WAIT_ZX = 2'b01,
    ST_ACCUM   = 2'b11
  } lc_state_t;

  typedef struct packed
  {
    lc_state_t                    state;
    logic                         zx_meta;
    logic                         zx_sync;
    logic                         zx_prev;
    logic [15:0]                  half_cycles;
    logic [15:0]                  remain;
    logic signed [`LCE_ACC_W-1:0] acc_p;
    logic signed [`LCE_ACC_W-1:0] acc_q;
    logic signed [`LCE_RES_W-1:0] res_p;
    logic signed [`LCE_RES_W-1:0] res_q;
    logic                         cycle_end;
    logic                         went_pos;
    logic                         went_neg;
    logic                         last_pos;
    logic                         sign_known;
    logic [`LCE_RES_W-1:0]        rdata;
  } acc_state_t;

  typedef struct packed
  {
    logic signed [31:0]           integ;
    logic signed [31:0]           lpf;
    logic signed [`LCE_RES_W-1:0] react;
    logic                         valid;
  } rp_state_t;

endpackage : lce_pkg

`default_nettype wire

// >>> shared/power_path_if.sv
// Purpose: samples to the reactive path and its filtered result back
// Assumes: one clock for both ends
// Notes:   valid strobes are one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "lce_defines.svh"

interface power_path_if;
  logic signed [`LCE_SMP_W-1:0] volt;
  logic signed [`LCE_SMP_W-1:0] curr;
  logic                         valid;
  logic signed [`LCE_RES_W-1:0] react;
  logic                         react_valid;

  modport host (output volt, output curr, output valid,
                input react, input react_valid);
  modport path (input volt, input curr, input valid,
                output react, output react_valid);
endinterface : power_path_if

`default_nettype wire
